// ---- verilog/otpcm_mode_ctrl.v ----
`timescale 1ns/1ps
`include "otpcm_regs.vh"
module otpcm_mode_ctrl #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3,
  parameter CW = 13
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // System bus register port
  input wire bus_wr_i,
  input wire bus_rd_i,
  input wire [31:0] bus_addr_i,
  input wire [31:0] bus_wdata_i,
  output wire [31:0] bus_rdata_o,
  // Serial interface register port
  input wire ser_wr_i,
  input wire [31:0] ser_wdata_i,
  // Trim register fields feeding the single word source
  input wire [15:0] bandgap_i,
  input wire [15:0] rssi_comp_i,
  input wire [7:0] rfio_ctrl1_i,
  input wire [4:0] lna_ctrl3_i,
  input wire [11:0] lna_ctrl2_i,
  input wire [11:0] lna_ctrl1_i,
  input wire [3:0] vco_ctrl_i,
  // Word count and start of an automatic program run
  input wire [CW-1:0] word_count_setting_i,
  input wire prog_start_i,
  // FIFO fill side (software port or DMA)
  input wire fifo_valid_i,
  output wire fifo_ready_o,
  input wire [WIDTH-1:0] fifo_data_i,
  output wire [AW:0] fifo_level_o,
  // Macrocell side
  output wire prog_valid_o,
  input wire prog_ready_i,
  output wire [WIDTH-1:0] prog_data_o,
  output wire prog_busy_o,
  output wire read_strobe_o,
  // Mode decode outputs
  output wire [2:0] operating_mode_o,
  output wire fast_program_timing_o,
  output wire dma_active_o,
  output wire test_mode_o
);
  // Sequencer states
  localparam ST_IDLE = 2'h0;
  localparam ST_FIFO = 2'h1;
  localparam ST_ONE = 2'h2;

  // Mode register fields
  reg [1:0] single_word_source_mux_r;
  reg fast_program_timing_r;
  reg single_word_source_select_r;
  reg two_cycle_read_pacing_r;
  reg fifo_flush_trigger_r;
  reg dma_transfer_enable_r;
  reg [2:0] operating_mode_field_r;

  // Sequencer state and words still to program
  reg [1:0] st_r;
  reg [1:0] st_nxt;
  reg [CW-1:0] left_r;
  reg [CW-1:0] left_nxt;

  // Combinational helpers
  reg [WIDTH-1:0] port_word;
  reg [31:0] wval;
  reg [31:0] rdval;

  // Internal nets
  wire bus_hit;
  wire any_wr;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [WIDTH-1:0] fifo_out_data;
  wire in_manual_read_mode;
  wire in_automatic_read_mode;
  wire in_automatic_program_mode;
  wire is_auto;
  wire read_run;
  wire take;

  // Address decode; the serial path carries no address
  assign bus_hit = (bus_addr_i == `OTPCM_MODE_ADDR);
  assign any_wr = (bus_wr_i && bus_hit) || ser_wr_i;

  // Serial write takes priority if both arrive together
  always @* begin
    wval = bus_wdata_i;
    if (ser_wr_i) begin
      wval = ser_wdata_i;
    end
    // Reserved positions are cut before anything is stored
    wval = wval & `OTPCM_WR_MASK;
  end

  // Reserved bits are never stored; each field below takes its slice of wval, save the DMA enable, which a serial write clears
  // Source selector for the single word port
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      single_word_source_mux_r <= 2'h0;
    end else if (any_wr) begin
      single_word_source_mux_r <= wval[`OTPCM_MUX_HI:`OTPCM_MUX_LO];
    end
  end

  // Programming timing choice, shared by every programming activity
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      fast_program_timing_r <= 1'b0;
    end else if (any_wr) begin
      fast_program_timing_r <= wval[`OTPCM_FAST_BIT];
    end
  end

  // Data source of an automatic program run
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      single_word_source_select_r <= 1'b0;
    end else if (any_wr) begin
      single_word_source_select_r <= wval[`OTPCM_PSEL_BIT];
    end
  end

  // Read pacing choice
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      two_cycle_read_pacing_r <= 1'b0;
    end else if (any_wr) begin
      two_cycle_read_pacing_r <= wval[`OTPCM_PACE_BIT];
    end
  end

  // Flush trigger stands one cycle; software never has to clear it
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      fifo_flush_trigger_r <= 1'b0;
    end else if (any_wr) begin
      fifo_flush_trigger_r <= wval[`OTPCM_FLUSH_BIT];
    end else begin
      fifo_flush_trigger_r <= 1'b0;
    end
  end

  // Serial path cannot launch bus mastering
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      dma_transfer_enable_r <= 1'b0;
    end else if (any_wr) begin
      dma_transfer_enable_r <= ser_wr_i ? 1'b0 : wval[`OTPCM_DMA_BIT];
    end
  end

  // Operating mode; direct active-to-active switches are software's duty to avoid
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      operating_mode_field_r <= `OTPCM_STANDBY;
    end else if (any_wr) begin
      operating_mode_field_r <= wval[`OTPCM_MODE_HI:`OTPCM_MODE_LO];
    end
  end

  // Read back; unimplemented bits are zero
  always @* begin
    rdval = 32'h00000000;
    if (bus_rd_i && bus_hit) begin
      rdval[`OTPCM_MUX_HI:`OTPCM_MUX_LO] = single_word_source_mux_r;
      rdval[`OTPCM_FAST_BIT] = fast_program_timing_r;
      rdval[`OTPCM_PSEL_BIT] = single_word_source_select_r;
      rdval[`OTPCM_PACE_BIT] = two_cycle_read_pacing_r;
      rdval[`OTPCM_FLUSH_BIT] = fifo_flush_trigger_r;
      rdval[`OTPCM_DMA_BIT] = dma_transfer_enable_r;
      rdval[`OTPCM_MODE_HI:`OTPCM_MODE_LO] = operating_mode_field_r;
    end
  end
  assign bus_rdata_o = rdval;

  // Single word source selection, zero padded
  always @* begin
    case (single_word_source_mux_r)
      2'h0: port_word = {16'h0000, bandgap_i};
      2'h1: port_word = {rssi_comp_i, 8'h00, rfio_ctrl1_i};
      2'h2: port_word = {3'h0, lna_ctrl3_i, lna_ctrl2_i, lna_ctrl1_i};
      2'h3: port_word = {28'h0000000, vco_ctrl_i};
      default: port_word = 32'h00000000;
    endcase
  end

  // Mode decode
  assign in_manual_read_mode = (operating_mode_field_r == `OTPCM_MANUAL_READ_MODE);
  assign in_automatic_read_mode = (operating_mode_field_r == `OTPCM_AUTOMATIC_READ_MODE);
  assign in_automatic_program_mode = (operating_mode_field_r == `OTPCM_AUTOMATIC_PROGRAM_MODE);
  assign is_auto = in_automatic_program_mode || in_automatic_read_mode;
  assign test_mode_o = operating_mode_field_r > `OTPCM_AUTOMATIC_PROGRAM_MODE;

  // Register fields straight to the pins
  assign operating_mode_o = operating_mode_field_r;
  assign fast_program_timing_o = fast_program_timing_r;

  // DMA idles when the single word port is the source
  assign dma_active_o = dma_transfer_enable_r && is_auto &&
    !(in_automatic_program_mode && single_word_source_select_r);

  // FIFO between fill side and macrocells
  // A flush wins over a push in the same cycle
  otpcm_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(fifo_flush_trigger_r),
    .in_valid_i(fifo_valid_i),
    .in_ready_o(fifo_ready_o),
    .in_data_i(fifo_data_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data),
    .level_o(fifo_level_o)
  );

  // Read pacing for manual and automatic read
  // Program and test modes hold the pacer cleared
  assign read_run = in_manual_read_mode || in_automatic_read_mode;
  otpcm_pacer u_pacer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(read_run),
    .two_cycle_i(two_cycle_read_pacing_r),
    .strobe_o(read_strobe_o)
  );

  // Automatic program sequencer
  always @* begin
    // Hold by default
    st_nxt = st_r;
    left_nxt = left_r;
    case (st_r)
      ST_IDLE: begin
        if (in_automatic_program_mode && prog_start_i) begin
          // Port source first: count and FIFO contents play no part
          if (single_word_source_select_r) begin
            st_nxt = ST_ONE;
          end else if (word_count_setting_i != {CW{1'b0}}) begin
            st_nxt = ST_FIFO;
            left_nxt = word_count_setting_i;
          end
        end
      end
      ST_FIFO: begin
        // The last accepted word closes the run
        if (take) begin
          left_nxt = left_r - {{(CW-1){1'b0}}, 1'b1};
          if (left_r == {{(CW-1){1'b0}}, 1'b1}) st_nxt = ST_IDLE;
        end
      end
      ST_ONE: begin
        // The live port word stands until the cells accept it
        if (prog_ready_i) st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
    // Leaving program mode drops the run at once
    if (!in_automatic_program_mode) st_nxt = ST_IDLE;
  end

  // Sequencer state; leaving program mode aborts the run
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= ST_IDLE;
      left_r <= {CW{1'b0}};
    end else begin
      st_r <= st_nxt;
      left_r <= left_nxt;
    end
  end

  // Macrocell handshake; the FIFO drains only while a FIFO run is open
  assign take = (st_r == ST_FIFO) && fifo_out_valid && prog_ready_i;
  assign fifo_out_ready = (st_r == ST_FIFO) && prog_ready_i;

  // Port word is used directly; FIFO and count ignored
  assign prog_valid_o = (st_r == ST_ONE) || ((st_r == ST_FIFO) && fifo_out_valid);
  assign prog_data_o = (st_r == ST_ONE) ? port_word : fifo_out_data;
  // Busy covers both sources until the last word is accepted
  assign prog_busy_o = (st_r != ST_IDLE);
endmodule // otpcm_mode_ctrl

// ---- inc/otpcm_regs.vh ----
`ifndef OTPCM_REGS_VH
`define OTPCM_REGS_VH
// Mode register location and reset
`define OTPCM_MODE_ADDR 32'h40008000
`define OTPCM_MODE_RST 32'h00000000
// Field positions
`define OTPCM_MUX_HI 29
`define OTPCM_MUX_LO 28
`define OTPCM_FAST_BIT 8
`define OTPCM_PSEL_BIT 7
`define OTPCM_PACE_BIT 6
`define OTPCM_FLUSH_BIT 5
`define OTPCM_DMA_BIT 4
`define OTPCM_MODE_HI 2
`define OTPCM_MODE_LO 0
// Writable bits mask
`define OTPCM_WR_MASK 32'h300001f7
// Operating mode codes
`define OTPCM_STANDBY 3'h0
`define OTPCM_MANUAL_READ_MODE 3'h1
`define OTPCM_MANUAL_PROGRAM_MODE 3'h2
`define OTPCM_AUTOMATIC_READ_MODE 3'h3
`define OTPCM_AUTOMATIC_PROGRAM_MODE 3'h4
// Read pacing counts in clock cycles
`define OTPCM_PACE_ONE 2'h1
`define OTPCM_PACE_TWO 2'h2
`endif

// ---- verilog/otpcm_fifo.v ----
`timescale 1ns/1ps
module otpcm_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  input wire flush_i,
  // Fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  // Fill level
  output wire [AW:0] level_o
);
  // Full level held at the counter's own width
  localparam [AW:0] LEVEL_FULL = DEPTH;
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;
  assign in_ready_o = (cnt_r != LEVEL_FULL) && !flush_i;
  assign out_valid_o = (cnt_r != {(AW+1){1'b0}}) && !flush_i;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_r[rp_r];
  assign level_o = cnt_r;
  // Pointers; flush drops all content at once
  always @(posedge clk_i) begin
    if (!rst_n_i || flush_i) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      if (push && !pop) cnt_r <= cnt_r + 1'b1;
      else if (pop && !push) cnt_r <= cnt_r - 1'b1;
    end
  end
  // Storage needs no reset
  always @(posedge clk_i) begin
    if (push) mem_r[wp_r] <= in_data_i;
  end
endmodule // otpcm_fifo

// ---- verilog/otpcm_pacer.v ----
`timescale 1ns/1ps
`include "otpcm_regs.vh"
module otpcm_pacer (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Control
  input wire run_i,
  input wire two_cycle_i,
  // Read strobe
  output wire strobe_o
);
  reg [1:0] cnt_r;
  wire [1:0] period;
  assign period = two_cycle_i ? `OTPCM_PACE_TWO : `OTPCM_PACE_ONE;
  assign strobe_o = run_i && (cnt_r == period - 2'h1);
  // Counts cycles per 16-bit read
  always @(posedge clk_i) begin
    if (!rst_n_i || !run_i) cnt_r <= 2'h0;
    else if (strobe_o) cnt_r <= 2'h0;
    else cnt_r <= cnt_r + 2'h1;
  end
endmodule // otpcm_pacer

// ---- testbench/otpcm_monitor.sv ----
`timescale 1ns/1ps
module otpcm_monitor #(
  parameter AW = 3
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Register ports
  input wire bus_wr_i,
  input wire bus_rd_i,
  input wire [31:0] bus_addr_i,
  input wire [31:0] bus_wdata_i,
  input wire [31:0] bus_rdata_o,
  input wire ser_wr_i,
  input wire [31:0] ser_wdata_i,
  // Observed outputs
  input wire fifo_ready_o,
  input wire [AW:0] fifo_level_o,
  input wire read_strobe_o,
  input wire [2:0] operating_mode_o,
  input wire fast_program_timing_o,
  input wire dma_active_o,
  input wire test_mode_o
);
  // Bus write that lands, serial port having priority
  wire hit = bus_wr_i && bus_addr_i == 32'h40008000 && !ser_wr_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_rsv_zero: assert property (bus_rd_i |-> (bus_rdata_o & ~32'h300001f7) == 0)
    else $error("reserved bits read nonzero");
  chk_bus_mode: assert property (hit |=> operating_mode_o == $past(bus_wdata_i[2:0]))
    else $error("mode not taken from bus write");
  chk_ser_dma: assert property (ser_wr_i |=> !dma_active_o ##0 operating_mode_o == $past(ser_wdata_i[2:0]))
    else $error("serial write kept dma");
  chk_fast_bit: assert property (hit |=> fast_program_timing_o == $past(bus_wdata_i[8]))
    else $error("timing bit wrong");
  chk_test_mode: assert property (test_mode_o == (operating_mode_o > 3'h4))
    else $error("test mode decode wrong");
  chk_strobe_mode: assert property (read_strobe_o |-> operating_mode_o inside {3'h1, 3'h3})
    else $error("read strobe outside read mode");
  chk_flush_empty: assert property (hit && bus_wdata_i[5] |=> !fifo_ready_o ##1 fifo_level_o == 0)
    else $error("flush left data");
  chk_dma_mode: assert property (dma_active_o |-> operating_mode_o inside {3'h3, 3'h4})
    else $error("dma active outside auto modes");
  chk_other_addr: assert property (bus_wr_i && bus_addr_i != 32'h40008000 && !ser_wr_i
    |=> $stable(operating_mode_o) && $stable(fast_program_timing_o))
    else $error("unmapped write changed mode");
endmodule // otpcm_monitor
bind otpcm_mode_ctrl otpcm_monitor #(.AW(AW)) i_otpcm_monitor (.*);

// ---- testbench/otpcm_cells.sv ----
`timescale 1ns/1ps
module otpcm_cells (
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Word from the controller
  input wire prog_valid_i,
  input wire [31:0] prog_data_i,
  output reg prog_ready_o,
  // Stall control
  input wire slow_i
);
  reg [31:0] got[$];
  // Slow runs stall at random so the sequencer must hold its word
  always @(posedge clk_i) begin
    if (rst_n_i && prog_valid_i && prog_ready_o) got.push_back(prog_data_i);
    prog_ready_o <= rst_n_i && (!slow_i || $urandom % 2);
  end
endmodule // otpcm_cells

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  localparam A = 32'h40008000;
  reg clk_i = 0, rst_n_i = 0, bus_wr_i = 0, bus_rd_i = 0, ser_wr_i = 0, prog_start_i = 0;
  reg fifo_valid_i = 0, slow = 0;
  reg [31:0] bus_addr_i = A, bus_wdata_i = 0, ser_wdata_i = 0, fifo_data_i = 0, d;
  reg [15:0] bandgap_i = 0, rssi_comp_i = 0;
  reg [7:0] rfio_ctrl1_i = 0;
  reg [4:0] lna_ctrl3_i = 0;
  reg [11:0] lna_ctrl2_i = 0, lna_ctrl1_i = 0;
  reg [3:0] vco_ctrl_i = 0;
  reg [12:0] word_count_setting_i = 0;
  wire [31:0] bus_rdata_o, prog_data_o;
  wire [3:0] fifo_level_o;
  wire [2:0] operating_mode_o;
  wire fifo_ready_o, prog_valid_o, prog_ready_i, prog_busy_o, read_strobe_o;
  wire fast_program_timing_o, dma_active_o, test_mode_o;
  integer errors = 0, samples_checked = 0, i, k, n;
  reg [31:0] q[$];
  otpcm_mode_ctrl i_otpcm_mode_ctrl (.*);
  otpcm_cells i_otpcm_cells (.clk_i(clk_i), .rst_n_i(rst_n_i), .prog_valid_i(prog_valid_o),
    .prog_data_i(prog_data_o), .prog_ready_o(prog_ready_i), .slow_i(slow));
  always #12.5 clk_i = ~clk_i;
  // Expected word on the single word source
  function [31:0] mux_word(input [1:0] s);
    case (s)
      2'h0: mux_word = {16'h0, bandgap_i};
      2'h1: mux_word = {rssi_comp_i, 8'h0, rfio_ctrl1_i};
      2'h2: mux_word = {3'h0, lna_ctrl3_i, lna_ctrl2_i, lna_ctrl1_i};
      default: mux_word = {28'h0, vco_ctrl_i};
    endcase
  endfunction
  task end_sim;
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task cmp(input string nm, input [31:0] e, input [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // Bus cycles start and end at a falling edge
  task wr(input [31:0] a, input [31:0] v);
    @(negedge clk_i) {bus_wr_i, bus_addr_i, bus_wdata_i} <= {1'b1, a, v};
    @(negedge clk_i) bus_wr_i <= 0;
  endtask
  task rd(input [31:0] a, input [31:0] e);
    @(negedge clk_i) {bus_rd_i, bus_addr_i} <= {1'b1, a};
    #1 cmp("rdata", e, bus_rdata_o);
    @(negedge clk_i) bus_rd_i <= 0;
  endtask
  // Always pass through standby so no active mode is left directly
  task go(input [31:0] v);
    wr(A, 0);
    wr(A, v);
  endtask
  task run(input [12:0] c);
    i_otpcm_cells.got.delete();
    {word_count_setting_i, prog_start_i} <= {c, 1'b1};
    @(negedge clk_i) prog_start_i <= 0;
    for (n = 0; n < 99 && prog_busy_o !== 1'b0; n++) @(negedge clk_i);
    cmp("busy", 0, prog_busy_o);
  endtask
  initial begin
    #(25 * 20000);
    errors++;
    end_sim;
  end
  initial begin
    d = $urandom(32'h0b5d);
    repeat (16) @(posedge clk_i);
    @(negedge clk_i) rst_n_i <= 1;
    rd(A, 0);
    for (i = 0; i < 8; i++) begin
      d = $urandom & 32'hfffffff8;
      wr(A, d);
      wr(A + 4, ~d);
      rd(A + 4, 0);
      rd(A, d & 32'h300001d7);
    end
    @(negedge clk_i) {ser_wr_i, ser_wdata_i} <= {1'b1, 32'h13};
    @(negedge clk_i) ser_wr_i <= 0;
    rd(A, 32'h3);
    for (i = 0; i < 8; i++) begin
      go(i);
      cmp("mode", i, operating_mode_o);
      cmp("test", i > 4, test_mode_o);
    end
    for (k = 0; k < 2; k++) begin
      go(32'h3 | (k << 6));
      for (n = 0, i = 0; i < 8; i++) @(negedge clk_i) n += read_strobe_o;
      cmp("strobes", k ? 4 : 8, n);
    end
    go(0);
    for (i = 0; i < 9; i++) begin
      d = $urandom;
      {fifo_valid_i, fifo_data_i} <= {1'b1, d};
      #1 cmp("ready", i < 8, fifo_ready_o);
      if (i < 8) q.push_back(d);
      @(negedge clk_i);
    end
    fifo_valid_i <= 0;
    cmp("level", 8, fifo_level_o);
    go(32'h14);
    cmp("dma", 1, dma_active_o);
    slow = 1;
    run(5);
    cmp("count", 5, i_otpcm_cells.got.size());
    for (i = 0; i < 5; i++) cmp("fword", q[i], i_otpcm_cells.got[i]);
    cmp("level", 3, fifo_level_o);
    for (k = 0; k < 4; k++) begin
      d = $urandom;
      {bandgap_i, rssi_comp_i} <= $urandom;
      {lna_ctrl1_i, lna_ctrl2_i, rfio_ctrl1_i} <= $urandom;
      {vco_ctrl_i, lna_ctrl3_i} <= d[8:0];
      go(32'h94 | (k << 28) | ((k & 1) << 8));
      cmp("dma", 0, dma_active_o);
      cmp("fast", k & 1, fast_program_timing_o);
      run(5);
      cmp("count", 1, i_otpcm_cells.got.size());
      cmp("pword", mux_word(k[1:0]), i_otpcm_cells.got[0]);
      cmp("level", 3, fifo_level_o);
    end
    wr(A, 32'h20);
    rd(A, 0);
    cmp("level", 0, fifo_level_o);
    // Reset in mid-run must bring every field back to its reset value
    go(32'h3000015b);
    @(negedge clk_i) rst_n_i <= 0;
    @(negedge clk_i) rst_n_i <= 1;
    rd(A, 0);
    cmp("rmode", 0, operating_mode_o);
    end_sim;
  end
endmodule // testbench
